// ---- wam_manager.sv ----
// Warning and alarm manager top level.
`timescale 1ns/10ps
// Contract
// - Eleven warnings exist: overheat and low charge per transmitter plus receiver overheat, fan and memory faults.
// - The audible alarm turns on whenever a warning is raised and shown.
// - The audible alarm turns off when the shown warning is acknowledged.
// - Transmitter overheat and low charge warnings are raised once per limit crossing, not while it persists.
// - A transmitter overheat warning switches that channel off for five minutes, then back on.
// - A transmitter temperature above the lower threshold turns its status indicator red.
// - A transmitter temperature above the upper threshold raises its overheat warning.
// - The receiver raises its own overheat warning above the same upper threshold.
// - A brief knob press dismisses the message, returns to the menu and acknowledges the warning.
module wam_manager #(
  parameter int CYC_PER_SEC = wam_pkg::WAM_CYC_PER_SEC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4*wam_pkg::WAM_TEMP_W-1:0] tx_temp,
  input wire logic [wam_pkg::WAM_NUM_TX-1:0] tx_low_charge,
  input wire logic [wam_pkg::WAM_TEMP_W-1:0] rx_temp,
  input wire logic rx_fan_fault,
  input wire logic rx_mem_fault,
  input wire logic knob_press,
  output logic alarm_on_r,
  output logic msg_valid_r,
  output logic [wam_pkg::WAM_MSG_W-1:0] msg_code_r,
  output logic [wam_pkg::WAM_NUM_TX-1:0] tx_led_red_r,
  output logic [wam_pkg::WAM_NUM_TX-1:0] chan_enable_r
);
  import wam_pkg::*;

  typedef enum logic [1:0] {
    WAM_IDLE = 2'b01,
    WAM_SHOW = 2'b10
  } wam_state_t;

  wam_state_t state_r;
  logic [WAM_PRE_W-1:0] pre_r;
  logic sec_tick_r;
  logic [WAM_NUM_MSG-1:0] cond;
  logic [WAM_NUM_MSG-1:0] cond_d_r;
  logic [WAM_NUM_MSG-1:0] pend_r;
  logic [WAM_NUM_MSG-1:0] raise;
  logic [WAM_NUM_TX-1:0] chan_busy;
  logic [WAM_NUM_TX-1:0] chan_done;
  logic [2:0] rx_busy;
  logic [2:0] rx_done;
  logic [WAM_MSG_W-1:0] pick;

  function automatic logic [WAM_MSG_W-1:0] first_set(input logic [WAM_NUM_MSG-1:0] v);
    logic [WAM_MSG_W-1:0] r;
    r = WAM_MSG_NONE;
    for (int i = WAM_NUM_MSG - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = WAM_MSG_W'(i);
      end
    end
    return r;
  endfunction

  // Message codes 0..3 overheat, 4..7 low charge, 8..10 receiver faults.
  genvar g;
  generate
    for (g = 0; g < WAM_NUM_TX; g++) begin : g_tx
      assign cond[g] = tx_temp[g*WAM_TEMP_W +: WAM_TEMP_W] > WAM_TEMP_WARN_C;
      assign cond[WAM_NUM_TX+g] = tx_low_charge[g];
      assign raise[g] = cond[g] && !cond_d_r[g];
      assign raise[WAM_NUM_TX+g] = cond[WAM_NUM_TX+g] && !cond_d_r[WAM_NUM_TX+g];
      wam_hold_timer #(.SEC_W(WAM_SEC_W), .LIMIT(9'(WAM_HOLD_SEC))) u_chan (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sec_tick(sec_tick_r),
        .start(raise[g]),
        .enable(1'b1),
        .busy(chan_busy[g]),
        .done(chan_done[g])
      );
    end
    for (g = 0; g < 3; g++) begin : g_rx
      assign raise[WAM_MSG_RX_HOT+g] = (cond[WAM_MSG_RX_HOT+g] && !cond_d_r[WAM_MSG_RX_HOT+g])
                                       || rx_done[g];
      wam_hold_timer #(.SEC_W(WAM_SEC_W), .LIMIT(9'(WAM_HOLD_SEC))) u_rx (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sec_tick(sec_tick_r),
        .start(raise[WAM_MSG_RX_HOT+g]),
        .enable(cond[WAM_MSG_RX_HOT+g]),
        .busy(rx_busy[g]),
        .done(rx_done[g])
      );
    end
  endgenerate

  assign cond[WAM_MSG_RX_HOT] = rx_temp > WAM_TEMP_WARN_C;
  assign cond[WAM_MSG_RX_FAN] = rx_fan_fault;
  assign cond[WAM_MSG_RX_MEM] = rx_mem_fault;
  assign pick = first_set(pend_r);

  // Seconds prescaler.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
      sec_tick_r <= 1'b0;
    end else begin
      sec_tick_r <= (pre_r == WAM_PRE_W'(CYC_PER_SEC - 1));
      if (pre_r == WAM_PRE_W'(CYC_PER_SEC - 1)) begin
        pre_r <= '0;
      end else begin
        pre_r <= pre_r + 1'b1;
      end
    end
  end

  // Condition history for edge detection.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cond_d_r <= '0;
    end else begin
      cond_d_r <= cond;
    end
  end

  // Pending warnings: a new raise wins over the acknowledge clear.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= WAM_PEND_RST;
    end else begin
      for (int i = 0; i < WAM_NUM_MSG; i++) begin
        if (raise[i]) begin
          pend_r[i] <= 1'b1;
        end else if (state_r == WAM_SHOW && knob_press && msg_code_r == WAM_MSG_W'(i)) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // Display and alarm sequencing.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= WAM_IDLE;
      msg_valid_r <= 1'b0;
      msg_code_r <= WAM_MSG_NONE;
      alarm_on_r <= 1'b0;
    end else begin
      unique case (state_r)
        WAM_IDLE: begin
          if (pick != WAM_MSG_NONE) begin
            state_r <= WAM_SHOW;
            msg_valid_r <= 1'b1;
            msg_code_r <= pick;
            alarm_on_r <= 1'b1;
          end
        end
        WAM_SHOW: begin
          if (knob_press) begin
            state_r <= WAM_IDLE;
            msg_valid_r <= 1'b0;
            msg_code_r <= WAM_MSG_NONE;
            alarm_on_r <= 1'b0;
          end
        end
        default: begin
          state_r <= WAM_IDLE;
        end
      endcase
    end
  end

  // Indicator and channel shut-off outputs.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_led_red_r <= '0;
      chan_enable_r <= '1;
    end else begin
      for (int i = 0; i < WAM_NUM_TX; i++) begin
        tx_led_red_r[i] <= tx_temp[i*WAM_TEMP_W +: WAM_TEMP_W] > WAM_TEMP_RED_C;
        chan_enable_r[i] <= !(raise[i] || chan_busy[i]);
      end
    end
  end

  chk_alarm_follows_show: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == WAM_IDLE && pick != WAM_MSG_NONE) |=> (alarm_on_r && msg_valid_r && msg_code_r == $past(pick)))
    else $error("Alarm not raised with shown warning.");
  chk_alarm_ack_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == WAM_SHOW && knob_press) |=> (!alarm_on_r && !msg_valid_r))
    else $error("Alarm not cleared on acknowledge.");
  chk_once_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(cond[4]) && cond[4]) |-> !raise[4])
    else $error("Low charge warning repeated.");
  chk_chan_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    raise[0] |=> !chan_enable_r[0])
    else $error("Channel not switched off on overheat.");
  chk_led_red: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tx_temp[7:0] > WAM_TEMP_RED_C) |=> tx_led_red_r[0])
    else $error("Indicator not red above lower threshold.");
  chk_warn_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cond[1] && !cond_d_r[1]) |=> pend_r[1])
    else $error("Overheat warning not pended.");
  chk_rx_hot: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rx_temp > WAM_TEMP_WARN_C && !cond_d_r[WAM_MSG_RX_HOT]) |=> pend_r[WAM_MSG_RX_HOT])
    else $error("Receiver overheat not pended.");
  chk_ack_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == WAM_SHOW && knob_press && !raise[msg_code_r]) |=> !pend_r[$past(msg_code_r)])
    else $error("Acknowledged warning still pending.");
  chk_rearm: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!cond_d_r[5] && cond[5]) |-> raise[5])
    else $error("Warning not re-armed.");
  chk_rx_repeat: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_done[1] |=> pend_r[WAM_MSG_RX_FAN])
    else $error("Fan fault not re-raised.");
  chk_chan_back: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (chan_done[0] && !raise[0]) |=> chan_enable_r[0])
    else $error("Channel not re-enabled after hold.");
  chk_rx_timer_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!cond[WAM_MSG_RX_FAN] && !raise[WAM_MSG_RX_FAN]) |=> !rx_busy[1])
    else $error("Fan fault timer kept running.");
endmodule // wam_manager

// ---- wam_pkg.sv ----
// Package of constants and types for the warning and alarm manager.
package wam_pkg;
  localparam int WAM_NUM_TX = 4;
  localparam int WAM_NUM_MSG = 11;
  localparam int WAM_MSG_W = 4;
  localparam int WAM_TEMP_W = 8;
  localparam logic [WAM_TEMP_W-1:0] WAM_TEMP_RED_C = 8'h41;
  localparam logic [WAM_TEMP_W-1:0] WAM_TEMP_WARN_C = 8'h4b;
  localparam int WAM_CLK_HZ = 25000000;
  localparam int WAM_SEC_S = 1;
  localparam int WAM_CYC_PER_SEC = WAM_CLK_HZ * WAM_SEC_S;
  localparam int WAM_HOLD_MIN = 5;
  localparam int WAM_HOLD_SEC = WAM_HOLD_MIN * 60;
  localparam int WAM_SEC_W = 9;
  localparam int WAM_PRE_W = 25;
  localparam int WAM_MSG_RX_HOT = 8;
  localparam int WAM_MSG_RX_FAN = 9;
  localparam int WAM_MSG_RX_MEM = 10;
  localparam logic [WAM_MSG_W-1:0] WAM_MSG_NONE = 4'hf;
  localparam logic [WAM_NUM_MSG-1:0] WAM_PEND_RST = 11'h000;
endpackage

// ---- wam_hold_timer.sv ----
// Five-minute seconds-based hold timer used per channel and per receiver fault.
`timescale 1ns/10ps
module wam_hold_timer #(
  parameter int SEC_W = 9,
  parameter logic [8:0] LIMIT = 9'h12c
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sec_tick,
  input wire logic start,
  input wire logic enable,
  output logic busy,
  output logic done
);
  logic [SEC_W-1:0] cnt_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= '0;
        busy <= 1'b1;
      end else if (!enable) begin
        busy <= 1'b0;
      end else if (busy && sec_tick) begin
        if (cnt_r == LIMIT - 9'h001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule // wam_hold_timer

// ---- wam_tx_model.sv ----
// Model of the four remote transmitters feeding temperature and charge status.
`timescale 1ns/10ps
module wam_tx_model #(
  parameter int SHUT_CYC = 120,
  parameter int RST_CYC = 600
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [31:0] cmd_temp,
  input wire logic [3:0] cmd_low,
  output logic [31:0] tx_temp,
  output logic [3:0] tx_low_charge
);
  int hot_cnt [4];
  int off_cnt [4];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_temp <= 32'h0;
      tx_low_charge <= 4'h0;
      hot_cnt <= '{default: 0};
      off_cnt <= '{default: 0};
    end else begin
      tx_low_charge <= cmd_low;
      for (int i = 0; i < 4; i++) begin
        if (off_cnt[i] > 0) begin
          off_cnt[i] <= off_cnt[i] - 1;
          tx_temp[8*i+:8] <= 8'h00;
        end else if (hot_cnt[i] == SHUT_CYC) begin
          off_cnt[i] <= RST_CYC;
          hot_cnt[i] <= 0;
        end else begin
          tx_temp[8*i+:8] <= cmd_temp[8*i+:8];
          hot_cnt[i] <= (cmd_temp[8*i+:8] > wam_pkg::WAM_TEMP_WARN_C) ? hot_cnt[i] + 1 : 0;
        end
      end
    end
  end
endmodule // wam_tx_model

// ---- tb.sv ----
// Self-checking testbench for the warning and alarm manager.
`timescale 1ns/10ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb;
  import wam_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] cmd_temp = 32'h0;
  logic [3:0] cmd_low = 4'h0;
  logic [31:0] tx_temp;
  logic [3:0] tx_low_charge;
  logic [7:0] rx_temp = 8'h14;
  logic rx_fan_fault = 1'b0;
  logic rx_mem_fault = 1'b0;
  logic knob_press = 1'b0;
  logic alarm_on_r, msg_valid_r;
  logic [3:0] msg_code_r, tx_led_red_r, chan_enable_r;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  int seed;
  logic [31:0] r;
  always #20 clk_sys = ~clk_sys;
  wam_tx_model #(.SHUT_CYC(120), .RST_CYC(600)) u_tx (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd_temp(cmd_temp), .cmd_low(cmd_low), .tx_temp(tx_temp), .tx_low_charge(tx_low_charge));
  wam_manager #(.CYC_PER_SEC(2)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .tx_temp(tx_temp),
    .tx_low_charge(tx_low_charge), .rx_temp(rx_temp), .rx_fan_fault(rx_fan_fault),
    .rx_mem_fault(rx_mem_fault), .knob_press(knob_press), .alarm_on_r(alarm_on_r),
    .msg_valid_r(msg_valid_r), .msg_code_r(msg_code_r), .tx_led_red_r(tx_led_red_r),
    .chan_enable_r(chan_enable_r));
  function automatic logic [3:0] exp_code(input int kind, input int k);
    return 4'(kind * 4 + k);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_msg(input logic [3:0] code, input int lim);
    int n;
    n = 0;
    while (msg_valid_r !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    `CHK("msg_code", code, msg_code_r)
    `CHK("alarm_on", 1'b1, alarm_on_r)
  endtask
  task automatic ack();
    knob_press = 1'b1;
    tick(1);
    knob_press = 1'b0;
    `CHK("msg_valid", 1'b0, msg_valid_r)
    `CHK("alarm_off", 1'b0, alarm_on_r)
    tick(1);
  endtask
  task automatic test_done();
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    seed = 11574;
    repeat (16) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    tick(1);
    `CHK("rst_code", WAM_MSG_NONE, msg_code_r)
    `CHK("rst_chan", 4'hf, chan_enable_r)
    ack();
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      cmd_temp = {4{r[7:0] % 8'h40}};
      cmd_low[k] = 1'b1;
      wait_msg(exp_code(1, k), 8);
      ack();
      tick(30);
      `CHK("no_repeat", 1'b0, msg_valid_r)
      cmd_low[k] = 1'b0;
      tick(3);
      cmd_low[k] = 1'b1;
      wait_msg(exp_code(1, k), 8);
      ack();
      cmd_temp[8*k+:8] = WAM_TEMP_RED_C + 8'h01;
      tick(8);
      `CHK("led_red", 4'h1 << k, tx_led_red_r)
      `CHK("no_warn", 1'b0, msg_valid_r)
      cmd_temp[8*k+:8] = WAM_TEMP_WARN_C + 8'h01;
      wait_msg(exp_code(0, k), 8);
      `CHK("chan_off", ~(4'h1 << k), chan_enable_r)
      ack();
      cmd_temp[8*k+:8] = WAM_TEMP_WARN_C;
      tick(500);
      `CHK("chan_held", ~(4'h1 << k), chan_enable_r)
      for (int n = 0; n < 200 && chan_enable_r !== 4'hf; n++) tick(1);
      `CHK("chan_back", 4'hf, chan_enable_r)
    end
    cmd_temp[23:16] = WAM_TEMP_WARN_C + 8'h05;
    wait_msg(exp_code(0, 2), 8);
    ack();
    tick(300);
    `CHK("led_shut", 4'h8, tx_led_red_r)
    `CHK("shut_quiet", 1'b0, msg_valid_r)
    tick(350);
    `CHK("chan_mid", 4'hf, chan_enable_r)
    wait_msg(exp_code(0, 2), 200);
    `CHK("chan_reoff", 4'hb, chan_enable_r)
    ack();
    cmd_temp[23:16] = WAM_TEMP_WARN_C;
    for (int n = 0; n < 700 && chan_enable_r !== 4'hf; n++) tick(1);
    `CHK("chan_again", 4'hf, chan_enable_r)
    rx_temp = WAM_TEMP_WARN_C + 8'h01;
    rx_mem_fault = 1'b1;
    wait_msg(4'h8, 8);
    ack();
    wait_msg(4'ha, 4);
    ack();
    rx_temp = WAM_TEMP_WARN_C;
    rx_mem_fault = 1'b0;
    rx_fan_fault = 1'b1;
    wait_msg(4'h9, 8);
    ack();
    tick(500);
    `CHK("fan_quiet", 1'b0, msg_valid_r)
    wait_msg(4'h9, 200);
    cmd_low = 4'h0;
    rst_n = 1'b0;
    tick(2);
    `CHK("rst2_valid", 1'b0, msg_valid_r)
    `CHK("rst2_code", WAM_MSG_NONE, msg_code_r)
    `CHK("rst2_alarm", 1'b0, alarm_on_r)
    `CHK("rst2_chan", 4'hf, chan_enable_r)
    rst_n = 1'b1;
    wait_msg(4'h9, 8);
    ack();
    rx_fan_fault = 1'b0;
    test_done();
  end
endmodule // tb
